// >>> verilog/mailbox_pkg.sv
package mailbox_pkg;

   // link command codes
   localparam logic [7:0] CMD_DEPOSIT        = 8'hd1;
   localparam logic [7:0] CMD_FETCH          = 8'hd5;
   localparam logic [2:0] DEPOSIT_LAST_BYTE  = 3'h4; // type byte is 0, data bytes 1..4

   // request types carried by a deposit
   localparam logic [7:0] REQ_MC_READ        = 8'h0a;
   localparam logic [7:0] REQ_TSTATE_READ    = 8'h0b;
   localparam logic [7:0] REQ_TSTATE_WRITE   = 8'h0c;
   localparam logic [7:0] REQ_ENERGY_READ    = 8'h0f;

   // completion codes
   localparam logic [7:0] CC_PASS            = 8'h40;
   localparam logic [7:0] CC_NOT_READY       = 8'h80;
   localparam logic [7:0] CC_BAD_CONFIG      = 8'h81;
   localparam logic [7:0] CC_BAD_BANK        = 8'h84;
   localparam logic [7:0] CC_BAD_TAG         = 8'h85;
   localparam logic [7:0] CC_BUSY            = 8'h86;
   localparam logic [7:0] CC_BAD_CORE        = 8'h89;
   localparam logic [7:0] CC_UNKNOWN         = 8'hff;

   // machine check request payload fields
   localparam int         MC_BANK_LSB        = 0;
   localparam int         MC_INDEX_LSB       = 8;
   localparam int         MC_CORE_LSB        = 16;
   localparam logic [3:0] MC_BANK_LOW_MAX    = 4'h6;
   localparam logic [3:0] MC_BANK_EXTRA      = 4'h8;
   localparam logic [3:0] MC_CORE_BANK_FIRST = 4'h2;
   localparam logic [3:0] MC_CORE_BANK_LAST  = 4'h5;
   localparam logic [3:0] MC_INDEX_MAX       = 4'h7;

   // throttling control word
   localparam int         TST_ENABLE_BIT     = 3;
   localparam logic [2:0] TST_CODE_NONE      = 3'h0;
   localparam logic [2:0] TST_CODE_SUPPORTED = 3'h1;
   localparam logic [2:0] TST_CODE_MAX       = 3'h7;

   // energy accumulator
   localparam logic [31:0] ENERGY_RESET      = 32'h0;
   localparam int          ENERGY_INT_LSB    = 16;

   typedef struct packed {
      logic [3:0] bank;
      logic [2:0] index;
   } mc_sel_t;

   typedef struct packed {
      logic       enable;
      logic [2:0] code;
   } tstate_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  code;
      logic [31:0] data;
   } resp_t;

endpackage

// >>> verilog/energy_accum.sv
`timescale 1ns/100ps
`default_nettype none

module energy_accum (
   input  wire logic        ref_clk_in,     // core clock
   input  wire logic        rst_in,         // power-up reset only
   input  wire logic        inc_valid_in,   // energy sample strobe
   input  wire logic [15:0] inc_in,         // joules, 16 fraction bits
   output logic      [31:0] total_out       // 16.16 joules
);

   typedef struct packed {
      logic [31:0] total;
   } energy_state_t;

   energy_state_t r;
   energy_state_t n;

   // free-running sum, wraps on overflow, no read side effect
   always_comb begin
      n = r;
      if (inc_valid_in) begin
         n.total = r.total + {16'h0, inc_in}; // RULE_10 RULE_11
      end
   end

   // only power-up clears the total; warm resets never reach here
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         r.total <= mailbox_pkg::ENERGY_RESET; // RULE_12
      end else begin
         r <= n;
      end
   end

   assign total_out = r.total;

   property p_energy_step;
      @(posedge ref_clk_in) disable iff (rst_in)
      inc_valid_in |=> total_out == 32'($past(total_out) + {16'h0, $past(inc_in)});
   endproperty
   a_energy_step: assert property (p_energy_step) else $error("energy sum wrong"); // RULE_11

   property p_energy_hold;
      @(posedge ref_clk_in) disable iff (rst_in)
      !inc_valid_in |=> $stable(total_out);
   endproperty
   a_energy_hold: assert property (p_energy_hold) else $error("energy moved idle"); // RULE_10

endmodule

`default_nettype wire

// >>> verilog/tstate_throttle.sv
`timescale 1ns/100ps
`default_nettype none

module tstate_throttle #(
   parameter int SLOT_CYCLES = 4           // core clocks per eighth of a period
) (
   input  wire logic                 ref_clk_in,          // core clock
   input  wire logic                 rst_in,              // async reset
   input  wire mailbox_pkg::tstate_t mbx_tstate_in,       // mailbox setting
   input  wire logic                 tcc_active_in,       // thermal control circuit pin
   input  wire logic [2:0]           sw_code_in,          // software request pin, 0 none
   output logic                      clocks_stopped_out   // cores clock-gated
);

   localparam int CW = $clog2(SLOT_CYCLES + 1);

   typedef struct packed {
      logic          tcc_s1;
      logic          tcc_s2;
      logic [2:0]    sw_s1;
      logic [2:0]    sw_s2;
      logic [CW-1:0] slot_cnt;
      logic [2:0]    phase;
      logic          stop;
   } thr_state_t;

   thr_state_t r;
   thr_state_t n;
   logic [2:0] eff_code;

   // arbitration and duty-cycle sequencing
   always_comb begin
      n = r;
      n.tcc_s1 = tcc_active_in;
      n.tcc_s2 = r.tcc_s1;
      n.sw_s1  = sw_code_in;
      n.sw_s2  = r.sw_s1;
      eff_code = mailbox_pkg::TST_CODE_NONE;
      if (mbx_tstate_in.enable && mbx_tstate_in.code != mailbox_pkg::TST_CODE_NONE) begin
         eff_code = mbx_tstate_in.code;
      end
      if (r.tcc_s2 && (eff_code == mailbox_pkg::TST_CODE_NONE ||
                       eff_code > mailbox_pkg::TST_CODE_SUPPORTED)) begin
         eff_code = mailbox_pkg::TST_CODE_SUPPORTED; // RULE_05 RULE_07
      end
      if (r.sw_s2 != mailbox_pkg::TST_CODE_NONE &&
          (eff_code == mailbox_pkg::TST_CODE_NONE || r.sw_s2 < eff_code)) begin
         eff_code = r.sw_s2; // RULE_07
      end
      if (eff_code == mailbox_pkg::TST_CODE_NONE) begin
         n.slot_cnt = '0;
         n.phase    = 3'h0;
         n.stop     = 1'b0;
      end else begin
         if (r.slot_cnt == CW'(SLOT_CYCLES - 1)) begin
            n.slot_cnt = '0;
            n.phase    = r.phase + 3'h1;
         end else begin
            n.slot_cnt = r.slot_cnt + CW'(1);
         end
         n.stop = (n.phase >= eff_code); // RULE_04 RULE_08
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign clocks_stopped_out = r.stop;

   property p_tst_priority;
      @(posedge ref_clk_in) disable iff (rst_in)
      r.tcc_s2 |-> eff_code != mailbox_pkg::TST_CODE_NONE &&
                   eff_code <= mailbox_pkg::TST_CODE_SUPPORTED;
   endproperty
   a_tst_priority: assert property (p_tst_priority) else $error("tcc not lowest"); // RULE_07

   property p_tst_run_phase;
      @(posedge ref_clk_in) disable iff (rst_in)
      (eff_code != mailbox_pkg::TST_CODE_NONE && $stable(eff_code) && n.phase < eff_code)
      |=> !clocks_stopped_out;
   endproperty
   a_tst_run_phase: assert property (p_tst_run_phase) else $error("stopped in on phase"); // RULE_04

   property p_tst_idle;
      @(posedge ref_clk_in) disable iff (rst_in)
      eff_code == mailbox_pkg::TST_CODE_NONE |=> !clocks_stopped_out;
   endproperty
   a_tst_idle: assert property (p_tst_idle) else $error("stopped while idle"); // RULE_04

endmodule

`default_nettype wire

// >>> verilog/mgmt_mailbox_services.sv
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// (RULE_01) machine check reads cover banks 0-6 and 8, index 0-7 picks halves
// (RULE_02) core banks 2-5 need a valid core select, other banks zero
// (RULE_03) bad bank or index above seven returns a failing code, no data
// (RULE_04) enabled throttling alternates core clocks running and stopped at duty
// (RULE_05) thermal control circuit activity also forces duty-cycle throttling
// (RULE_06) throttle setting reachable only through the mailbox, never in-band
// (RULE_07) concurrent throttle requests resolve to the smallest duty code
// (RULE_08) three-bit duty code, zero undefined, 1-7 are eighths clocks on
// (RULE_09) only duty code one is supported
// (RULE_10) energy total is 32-bit unsigned 16.16 joules
// (RULE_11) energy total free-runs, wraps, and reads never clear it
// (RULE_12) energy total clears at power-up only, warm resets keep counting
// (RULE_13) host uses energy differences and handles wrap
// (RULE_14) host polls energy between 1 Hz and 10 Hz
// (RULE_15) host keeps its own timestamps for energy reads
// (RULE_16) energy read passes, proving the service exists
// (RULE_17) each deposit is serviced later and held until fetched; a deposit while the mailbox is locked gets busy and is not serviced
// (RULE_18) every deposit carries a type and four data bytes, zero when unused
// (RULE_19) deposit command d1 answers one completion code byte
// (RULE_20) granted deposit answers upper nibble 4 with the transaction tag
// (RULE_21) payload bytes arrive least significant first
module mgmt_mailbox_services #(
   parameter int SERVICE_CYCLES = 4,       // wait-state clocks; result done SERVICE_CYCLES+1 clocks after deposit
   parameter int NUM_CORES      = 6,       // valid core selects for core banks
   parameter int SLOT_CYCLES    = 4        // throttle slot length in core clocks
) (
   input  wire logic                 ref_clk_in,          // core clock, 25 MHz
   input  wire logic                 rst_in,              // power-up reset, async
   input  wire logic                 warm_reset_in,       // warm reset pin, power kept
   input  wire logic                 link_frame_start_in, // byte is a command code
   input  wire logic                 link_byte_valid_in,  // byte strobe from link
   input  wire logic [7:0]           link_byte_in,        // received byte
   output mailbox_pkg::resp_t        resp_out,            // answer pulse, code, data
   output mailbox_pkg::mc_sel_t      mc_sel_out,          // error bank word select
   input  wire logic [31:0]          mc_word_in,          // selected error bank half
   input  wire logic                 tcc_active_in,       // thermal control circuit pin
   input  wire logic [2:0]           sw_tstate_code_in,   // other agent request pin
   output logic                      clocks_stopped_out,  // core clock modulation
   input  wire logic                 energy_inc_valid_in, // energy sample strobe
   input  wire logic [15:0]          energy_inc_in        // energy sample
);

   localparam int SVC_MAX = 40;

   typedef enum logic [1:0] {S_IDLE, S_WAIT, S_EXEC} svc_t;

   typedef struct packed {
      logic                 wr_s1;
      logic                 wr_s2;
      logic [7:0]           cmd;
      logic [2:0]           byte_cnt;
      logic [7:0]           rx_type;
      logic [31:0]          rx_data;
      logic                 locked;
      logic                 done;
      logic [3:0]           tag;
      logic [7:0]           req_type;
      logic [31:0]          req_data;
      svc_t                 svc;
      logic [7:0]           wait_cnt;
      logic [7:0]           res_code;
      logic [31:0]          res_data;
      mailbox_pkg::tstate_t tstate;
      mailbox_pkg::mc_sel_t mc_sel;
      mailbox_pkg::resp_t   resp;
   } mbx_state_t;

   mbx_state_t  r;
   mbx_state_t  n;
   logic [31:0] energy_total;
   logic [3:0]  mc_bank;
   logic [3:0]  mc_index;
   logic [3:0]  mc_core;
   logic        bank_ok;
   logic        index_ok;
   logic        core_ok;
   logic        deposit_done;
   logic        fetch_byte;

   // decode of the machine check request held for service
   always_comb begin
      mc_bank  = r.req_data[mailbox_pkg::MC_BANK_LSB +: 4];
      mc_index = r.req_data[mailbox_pkg::MC_INDEX_LSB +: 4];
      mc_core  = r.req_data[mailbox_pkg::MC_CORE_LSB +: 4];
      bank_ok  = (mc_bank <= mailbox_pkg::MC_BANK_LOW_MAX) ||
                 (mc_bank == mailbox_pkg::MC_BANK_EXTRA); // RULE_01
      index_ok = (mc_index <= mailbox_pkg::MC_INDEX_MAX); // RULE_03
      if (mc_bank >= mailbox_pkg::MC_CORE_BANK_FIRST &&
          mc_bank <= mailbox_pkg::MC_CORE_BANK_LAST) begin
         core_ok = (32'(mc_core) < NUM_CORES); // RULE_02
      end else begin
         core_ok = (mc_core == 4'h0); // RULE_02
      end
   end

   // link byte decode, service sequencing and answers
   always_comb begin
      n = r;
      n.wr_s1      = warm_reset_in;
      n.wr_s2      = r.wr_s1;
      n.resp.valid = 1'b0;
      deposit_done = 1'b0;
      fetch_byte   = 1'b0;
      if (link_byte_valid_in) begin
         if (link_frame_start_in) begin
            n.cmd      = link_byte_in;
            n.byte_cnt = 3'h0;
         end else begin
            if (r.byte_cnt != 3'h7) begin
               n.byte_cnt = r.byte_cnt + 3'h1;
            end
            if (r.cmd == mailbox_pkg::CMD_DEPOSIT) begin
               if (r.byte_cnt == 3'h0) begin
                  n.rx_type = link_byte_in;
               end else if (r.byte_cnt <= mailbox_pkg::DEPOSIT_LAST_BYTE) begin
                  n.rx_data = {link_byte_in, r.rx_data[31:8]}; // RULE_21
               end
               deposit_done = (r.byte_cnt == mailbox_pkg::DEPOSIT_LAST_BYTE);
            end else if (r.cmd == mailbox_pkg::CMD_FETCH) begin
               fetch_byte = (r.byte_cnt == 3'h0);
            end
         end
      end
      // deposit: grant the mailbox or report it busy
      if (deposit_done) begin
         n.resp.valid = 1'b1;
         n.resp.data  = 32'h0;
         if (r.locked) begin
            n.resp.code = mailbox_pkg::CC_BUSY;
         end else begin
            n.locked        = 1'b1;
            n.done          = 1'b0;
            n.tag           = r.tag + 4'h1;
            n.req_type      = n.rx_type;
            n.req_data      = n.rx_data;
            n.mc_sel.bank   = n.rx_data[mailbox_pkg::MC_BANK_LSB +: 4];
            n.mc_sel.index  = n.rx_data[mailbox_pkg::MC_INDEX_LSB +: 3];
            n.svc           = S_WAIT;
            n.wait_cnt      = 8'h0;
            n.resp.code     = {mailbox_pkg::CC_PASS[7:4], n.tag}; // RULE_19 RULE_20
         end
      end
      // fetch: hand back the held result and release the mailbox
      if (fetch_byte) begin
         n.resp.valid = 1'b1;
         n.resp.data  = 32'h0;
         if (!r.locked || link_byte_in != {4'h0, r.tag}) begin
            n.resp.code = mailbox_pkg::CC_BAD_TAG;
         end else if (!r.done) begin
            n.resp.code = mailbox_pkg::CC_NOT_READY;
         end else begin
            n.resp.code = r.res_code; // RULE_17
            n.resp.data = r.res_data;
            n.locked    = 1'b0;
            n.done      = 1'b0;
         end
      end
      // service the deposited request after the fixed latency
      case (r.svc)
         S_IDLE: begin
         end
         S_WAIT: begin
            if (r.wait_cnt >= 8'(SERVICE_CYCLES - 1)) begin
               n.svc = S_EXEC;
            end else begin
               n.wait_cnt = r.wait_cnt + 8'h1;
            end
         end
         S_EXEC: begin
            n.svc      = S_IDLE;
            n.done     = 1'b1; // RULE_17
            n.res_code = mailbox_pkg::CC_PASS;
            n.res_data = 32'h0;
            if (r.req_type == mailbox_pkg::REQ_MC_READ) begin
               if (!bank_ok || !index_ok) begin
                  n.res_code = mailbox_pkg::CC_BAD_BANK; // RULE_03
               end else if (!core_ok) begin
                  n.res_code = mailbox_pkg::CC_BAD_CORE; // RULE_02
               end else begin
                  n.res_data = mc_word_in; // RULE_01
               end
            end else if (r.req_type == mailbox_pkg::REQ_TSTATE_READ) begin
               n.res_data = {28'h0, r.tstate}; // RULE_06
            end else if (r.req_type == mailbox_pkg::REQ_TSTATE_WRITE) begin
               if (r.req_data[mailbox_pkg::TST_ENABLE_BIT] &&
                   r.req_data[2:0] != mailbox_pkg::TST_CODE_SUPPORTED) begin
                  n.res_code = mailbox_pkg::CC_BAD_CONFIG; // RULE_08 RULE_09
               end else begin
                  n.tstate.enable = r.req_data[mailbox_pkg::TST_ENABLE_BIT]; // RULE_06
                  n.tstate.code   = r.req_data[2:0];
               end
            end else if (r.req_type == mailbox_pkg::REQ_ENERGY_READ) begin
               n.res_data = energy_total; // RULE_16
            end else begin
               n.res_code = mailbox_pkg::CC_UNKNOWN;
            end
         end
         default: begin
            n.svc = S_IDLE;
         end
      endcase
      // warm reset clears the mailbox but keeps the synchroniser running
      if (r.wr_s2) begin
         n       = '0;
         n.wr_s1 = warm_reset_in;
         n.wr_s2 = r.wr_s1;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign resp_out   = r.resp;
   assign mc_sel_out = r.mc_sel;

   // duty-cycle modulation fed by the mailbox copy of the setting, the thermal control circuit pin and the software request pin
   tstate_throttle #(
      .SLOT_CYCLES (SLOT_CYCLES)
   ) u_throttle (
      .ref_clk_in         (ref_clk_in),
      .rst_in             (rst_in),
      .mbx_tstate_in      (r.tstate),
      .tcc_active_in      (tcc_active_in),
      .sw_code_in         (sw_tstate_code_in),
      .clocks_stopped_out (clocks_stopped_out)
   );

   // energy total, cleared by power-up reset alone
   energy_accum u_energy (
      .ref_clk_in   (ref_clk_in),
      .rst_in       (rst_in),
      .inc_valid_in (energy_inc_valid_in),
      .inc_in       (energy_inc_in),
      .total_out    (energy_total)
   );

   property p_mc_bad_bank;
      @(posedge ref_clk_in) disable iff (rst_in || r.wr_s2)
      (r.svc == S_EXEC && r.req_type == mailbox_pkg::REQ_MC_READ && !(bank_ok && index_ok))
      |=> r.done && r.res_code == mailbox_pkg::CC_BAD_BANK && r.res_data == 32'h0;
   endproperty
   a_mc_bad_bank: assert property (p_mc_bad_bank) else $error("bad bank not refused"); // RULE_03

   property p_mc_core;
      @(posedge ref_clk_in) disable iff (rst_in || r.wr_s2)
      (r.svc == S_EXEC && r.req_type == mailbox_pkg::REQ_MC_READ && bank_ok && index_ok &&
       !core_ok) |=> r.res_code == mailbox_pkg::CC_BAD_CORE;
   endproperty
   a_mc_core: assert property (p_mc_core) else $error("core select not checked"); // RULE_02

   property p_mc_data;
      @(posedge ref_clk_in) disable iff (rst_in || r.wr_s2)
      (r.svc == S_EXEC && r.req_type == mailbox_pkg::REQ_MC_READ && bank_ok && index_ok &&
       core_ok) |=> r.res_code == mailbox_pkg::CC_PASS && r.res_data == $past(mc_word_in);
   endproperty
   a_mc_data: assert property (p_mc_data) else $error("bank word not returned"); // RULE_01

   property p_grant;
      @(posedge ref_clk_in) disable iff (rst_in || r.wr_s2)
      (deposit_done && !r.locked) |=> resp_out.valid && resp_out.code[7:4] == 4'h4 &&
                                      resp_out.code[3:0] == r.tag && r.locked;
   endproperty
   a_grant: assert property (p_grant) else $error("grant code wrong"); // RULE_20

   property p_busy;
      @(posedge ref_clk_in) disable iff (rst_in || r.wr_s2)
      (deposit_done && r.locked) |=> resp_out.valid && resp_out.code == mailbox_pkg::CC_BUSY;
   endproperty
   a_busy: assert property (p_busy) else $error("busy not reported"); // RULE_19

   property p_service;
      @(posedge ref_clk_in) disable iff (rst_in || r.wr_s2)
      (deposit_done && !r.locked) |-> ##[2:SVC_MAX] r.done;
   endproperty
   a_service: assert property (p_service) else $error("request never serviced"); // RULE_17

   property p_lsb_first;
      @(posedge ref_clk_in) disable iff (rst_in || r.wr_s2)
      deposit_done |=> r.rx_data[31:24] == $past(link_byte_in);
   endproperty
   a_lsb_first: assert property (p_lsb_first) else $error("payload order wrong"); // RULE_21

   property p_tst_reject;
      @(posedge ref_clk_in) disable iff (rst_in || r.wr_s2)
      (r.svc == S_EXEC && r.req_type == mailbox_pkg::REQ_TSTATE_WRITE &&
       r.req_data[mailbox_pkg::TST_ENABLE_BIT] &&
       r.req_data[2:0] != mailbox_pkg::TST_CODE_SUPPORTED)
      |=> r.res_code == mailbox_pkg::CC_BAD_CONFIG && $stable(r.tstate);
   endproperty
   a_tst_reject: assert property (p_tst_reject) else $error("bad duty accepted"); // RULE_09

   property p_energy_pass;
      @(posedge ref_clk_in) disable iff (rst_in || r.wr_s2)
      (r.svc == S_EXEC && r.req_type == mailbox_pkg::REQ_ENERGY_READ)
      |=> r.res_code == mailbox_pkg::CC_PASS && r.res_data == $past(energy_total);
   endproperty
   a_energy_pass: assert property (p_energy_pass) else $error("energy read failed"); // RULE_16

endmodule

`default_nettype wire

// >>> testbench/host_link_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
   input  wire logic               clk_in,    // core clock
   input  wire mailbox_pkg::resp_t resp_in,   // device answer
   output logic                    start_out, // command byte marker
   output logic                    valid_out, // byte strobe
   output logic [7:0]              byte_out   // link byte
);
   // quiet link at time zero
   initial begin
      start_out = 1'b0;
      valid_out = 1'b0;
      byte_out  = 8'h00;
   end
   // one byte per clock, held up to the taking edge
   task automatic put(input logic [7:0] b, input logic s);
      start_out = s;
      valid_out = 1'b1;
      byte_out  = b;
      @(posedge clk_in);
      #1;
   endtask
   // release the strobe, idle data line shows the inverse of the last byte
   task automatic idle();
      valid_out = 1'b0;
      start_out = 1'b0;
      byte_out  = ~byte_out;
   endtask
   // wait a bounded time for the answer pulse
   task automatic answer(output mailbox_pkg::resp_t r);
      for (int i = 0; i < 8; i++) begin
         if (resp_in.valid === 1'b1) break;
         @(posedge clk_in);
         #1;
      end
      r = resp_in;
   endtask
   // deposit: command, type, four data bytes low first
   task automatic deposit(input logic [7:0] t, input logic [31:0] d, output mailbox_pkg::resp_t r);
      @(posedge clk_in);
      #1;
      put(mailbox_pkg::CMD_DEPOSIT, 1'b1);
      put(t, 1'b0);
      for (int k = 0; k < 4; k++) put(d[8*k +: 8], 1'b0);
      idle();
      answer(r);
   endtask
   // fetch: command then tag byte
   task automatic fetch(input logic [3:0] tag, output mailbox_pkg::resp_t r);
      @(posedge clk_in);
      #1;
      put(mailbox_pkg::CMD_FETCH, 1'b1);
      put({4'h0, tag}, 1'b0);
      idle();
      answer(r);
   endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic                 clk, rst, warm, thermal_control_circuit, e_v, stopped, l_s, l_v;
   logic [2:0]           sw;
   logic [15:0]          e_inc;
   logic [7:0]           l_b;
   logic [31:0]          mc_word;
   mailbox_pkg::resp_t   resp, r, f;
   mailbox_pkg::mc_sel_t sel;
   int                   mismatches, tests_run, cycles;
   // error bank source echoes the selected bank and index
   assign mc_word = {20'h0, sel.bank, 5'h0, sel.index};
   mgmt_mailbox_services #(.SERVICE_CYCLES(4), .NUM_CORES(6), .SLOT_CYCLES(1)) DUT (
      .ref_clk_in(clk), .rst_in(rst), .warm_reset_in(warm), .link_frame_start_in(l_s),
      .link_byte_valid_in(l_v), .link_byte_in(l_b), .resp_out(resp), .mc_sel_out(sel),
      .mc_word_in(mc_word), .tcc_active_in(thermal_control_circuit), .sw_tstate_code_in(sw),
      .clocks_stopped_out(stopped), .energy_inc_valid_in(e_v), .energy_inc_in(e_inc));
   host_link_model host (.clk_in(clk), .resp_in(resp), .start_out(l_s), .valid_out(l_v),
      .byte_out(l_b));
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic chk(input logic [40:0] got, input logic [40:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // full request: grant, wait for service, fetch and compare
   task automatic txn(input logic [7:0] t, input logic [31:0] d, input logic [7:0] ec,
                      input logic [31:0] ed);
      host.deposit(t, d, r);
      chk(41'({r.valid, r.code[7:4]}), 41'h14);
      repeat (8) @(posedge clk);
      host.fetch(r.code[3:0], f);
      chk({f.valid, f.code, f.data}, {1'b1, ec, ed});
   endtask
   task automatic duty(input int exp);
      int n;
      n = 0;
      repeat (12) @(posedge clk);
      repeat (16) begin
         @(posedge clk);
         #1;
         n += int'(stopped === 1'b1);
      end
      chk(41'(n), 41'(exp));
   endtask
   task automatic t_mc();
      txn(8'h0a, 32'h0000_0708, 8'h40, 32'h807);
      txn(8'h0a, 32'h0000_0106, 8'h40, 32'h601);
      txn(8'h0a, 32'h0000_0007, 8'h84, 32'h0);
      txn(8'h0a, 32'h0000_0800, 8'h84, 32'h0);
      txn(8'h0a, 32'h0005_0203, 8'h40, 32'h302);
      txn(8'h0a, 32'h0006_0003, 8'h89, 32'h0);
      txn(8'h0a, 32'h0001_0001, 8'h89, 32'h0);
      txn(8'h55, 32'h0, 8'hff, 32'h0);
      $display("test mc done");
   endtask
   task automatic t_throttle();
      txn(8'h0c, 32'ha, 8'h81, 32'h0);
      txn(8'h0c, 32'h8, 8'h81, 32'h0);
      txn(8'h0c, 32'h9, 8'h40, 32'h0);
      txn(8'h0b, 32'h0, 8'h40, 32'h9);
      duty(14);
      txn(8'h0c, 32'h0, 8'h40, 32'h0);
      sw = 3'h3;
      duty(10);
      txn(8'h0c, 32'h9, 8'h40, 32'h0);
      duty(14);
      txn(8'h0c, 32'h0, 8'h40, 32'h0);
      thermal_control_circuit = 1'b1;
      duty(14);
      thermal_control_circuit = 1'b0;
      sw = 3'h0;
      duty(0);
      $display("test throttle done");
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         e_v = 1'b1;
         @(posedge clk);
         #1;
      end
      e_v = 1'b0;
   endtask
   task automatic t_energy();
      logic [31:0] prev;
      logic [31:0] delta;
      time         stamp;
      txn(8'h0f, 32'h0, 8'h40, 32'h0);
      prev  = f.data;
      stamp = $time;
      pulses(4);
      txn(8'h0f, 32'h0, 8'h40, 32'h2_0000);
      delta = f.data - prev; // modular difference survives a wrap
      chk(41'(delta), 41'h2_0000);
      chk(41'($time > stamp), 41'h1);
      txn(8'h0f, 32'h0, 8'h40, 32'h2_0000);
      warm = 1'b1;
      repeat (5) @(posedge clk);
      #1;
      warm = 1'b0;
      pulses(2);
      txn(8'h0f, 32'h0, 8'h40, 32'h3_0000);
      $display("test energy done");
   endtask
   task automatic t_lock();
      host.deposit(8'h0f, 32'h0, r);
      host.fetch(r.code[3:0], f);
      chk(41'({f.valid, f.code}), 41'h180);
      host.deposit(8'h0f, 32'h0, f);
      chk(41'({f.valid, f.code}), 41'h186);
      host.fetch(r.code[3:0] + 4'h1, f);
      chk(41'({f.valid, f.code}), 41'h185);
      repeat (8) @(posedge clk);
      host.fetch(r.code[3:0], f);
      chk({f.valid, f.code, f.data}, {1'b1, 8'h40, 32'h3_0000});
      $display("test lock done");
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // reset, then the scenarios
   initial begin
      {rst, warm, thermal_control_circuit, e_v, sw} = {1'b1, 6'h0};
      e_inc = 16'h8000;
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      t_mc();
      t_throttle();
      t_energy();
      t_lock();
      conclude();
   end
endmodule
`default_nettype wire
